// [core/flash_host.sv]
`timescale 1ns/100ps
// host controller driving the dual-bank flash through its strobe pins
`include "flash_host_defines.svh"
module flash_host
    import flash_host_pkg::*;
#(
    parameter int CLEAR_SETTLE_CYCLES = `CLEAR_SETTLE_CYC
)(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // software port
    input wire logic [3:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_write,
    input wire logic sw_read,
    output logic [31:0] sw_rdata,
    // flash control pins
    output logic chip_select_n,
    output logic output_gate_n,
    output logic write_strobe_n,
    output logic hard_clear_n,
    output logic width_select_n,
    output logic accel_enable,
    output logic [20:0] flash_addr,
    // data bus, two-way (bit 15 is top_data_or_low_addr)
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic [15:0] data_oe,
    // completion indicator from the device
    input wire logic completion_indicator
);
    host_state_t state_reg;
    logic [`CNT_W-1:0] count_reg;
    logic [1:0] seq_idx_reg;
    logic [1:0] seq_last_reg;
    logic is_read_reg;
    logic byte_mode_reg;
    logic accel_reg;
    logic busy_reg;
    logic clear_seen_busy_reg;
    logic [21:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic [2:0] ready_sync_reg;
    logic ready_reg;
    logic [37:0] seq_word;
    logic seq_wr;
    logic [1:0] seq_rd_idx;

    // byte address to pin address, byte mode puts the low bit on line 15
    function automatic logic [20:0] pin_addr(input logic [21:0] a, input logic bm);
        pin_addr = bm ? a[21:1] : a[20:0];
    endfunction

    // clamp a cycle count to at least one
    function automatic logic [`CNT_W-1:0] cyc(input int n);
        cyc = (n < 1) ? `CNT_W'(1) : `CNT_W'(n);
    endfunction

    assign seq_wr = sw_write && (sw_addr >= `REG_SEQ0);

    // store read is registered, so address the word the next setup cycle will need
    always_comb begin
        seq_rd_idx = seq_idx_reg;
        if (state_reg == ST_IDLE) begin
            seq_rd_idx = 2'h0;
        end else if (state_reg == ST_RECOVER) begin
            seq_rd_idx = seq_idx_reg + 2'h1;
        end
    end

    seq_store u_seq (
        .clk(clk),
        .wr_en(seq_wr),
        .wr_idx(sw_addr[1:0]),
        .wr_word({sw_wdata[31:16], sw_wdata[21:0]}),
        .rd_idx(seq_rd_idx),
        .rd_word(seq_word)
    );

    // completion indicator is asynchronous: three stages, change when last two agree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ready_sync_reg <= 3'h7;
            ready_reg <= 1'h1;
        end else begin
            ready_sync_reg <= {ready_sync_reg[1:0], completion_indicator};
            if (ready_sync_reg[2] == ready_sync_reg[1]) begin
                ready_reg <= ready_sync_reg[2];
            end
        end
    end

    // software-set configuration
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            byte_mode_reg <= 1'h0;
            accel_reg <= 1'h0;
            addr_reg <= 22'h0;
            wdata_reg <= 16'h0;
            seq_last_reg <= 2'h0;
        end else if (sw_write) begin
            unique case (sw_addr)
                `REG_CTRL: begin
                    byte_mode_reg <= sw_wdata[`CTRL_BYTE];
                    // high voltage only requested while idle, for accelerated programs
                    if (state_reg == ST_IDLE) begin
                        accel_reg <= sw_wdata[`CTRL_ACCEL];
                    end
                    seq_last_reg <= 2'(sw_wdata[`CTRL_SEQ_LEN_HI:`CTRL_SEQ_LEN_LO]);
                end
                `REG_ADDR: addr_reg <= sw_wdata[21:0];
                `REG_WDATA: wdata_reg <= sw_wdata[15:0];
                default: ;
            endcase
        end
    end

    // bus cycle sequencer: queued writes (two for bypass/accel, four standard), reads, clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            count_reg <= `CNT_W'h0;
            seq_idx_reg <= 2'h0;
            is_read_reg <= 1'h0;
            busy_reg <= 1'h0;
            clear_seen_busy_reg <= 1'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (sw_write && sw_addr == `REG_CTRL && sw_wdata[`CTRL_CLEAR]) begin
                        state_reg <= ST_CLEAR_LOW;
                        count_reg <= cyc(`CLEAR_PULSE_CYC);
                        clear_seen_busy_reg <= !ready_reg;
                        busy_reg <= 1'h1;
                    end else if (sw_write && sw_addr == `REG_CTRL && sw_wdata[`CTRL_GO]) begin
                        is_read_reg <= sw_wdata[`CTRL_READ];
                        seq_idx_reg <= 2'h0;
                        busy_reg <= 1'h1;
                        state_reg <= ST_SETUP;
                        count_reg <= cyc(1);
                    end
                end
                ST_SETUP: begin
                    // one cycle for the stored word to appear on the pins
                    state_reg <= is_read_reg ? ST_READ_WAIT : ST_STROBE;
                    count_reg <= is_read_reg ? cyc(`SELECT_ACCESS_CYC + 1)
                                             : cyc(`WRITE_PULSE_CYC);
                end
                ST_STROBE: begin
                    if (count_reg == `CNT_W'h1) begin
                        state_reg <= ST_RECOVER;
                        count_reg <= cyc(`RECOVER_CYC);
                    end else begin
                        count_reg <= count_reg - `CNT_W'h1;
                    end
                end
                ST_RECOVER: begin
                    if (count_reg != `CNT_W'h1) begin
                        count_reg <= count_reg - `CNT_W'h1;
                    end else if (seq_idx_reg == seq_last_reg) begin
                        // program/erase keeps running in the device; we just deselect
                        state_reg <= ST_IDLE;
                        busy_reg <= 1'h0;
                    end else begin
                        seq_idx_reg <= seq_idx_reg + 2'h1;
                        state_reg <= ST_SETUP;
                    end
                end
                ST_READ_WAIT: begin
                    if (count_reg == `CNT_W'h1) begin
                        state_reg <= ST_IDLE;
                        busy_reg <= 1'h0;
                    end else begin
                        count_reg <= count_reg - `CNT_W'h1;
                    end
                end
                ST_CLEAR_LOW: begin
                    if (count_reg == `CNT_W'h1) begin
                        state_reg <= ST_CLEAR_SETTLE;
                        count_reg <= clear_seen_busy_reg ? cyc(CLEAR_SETTLE_CYCLES)
                                                         : cyc(`CLEAR_RELEASE_CYC);
                    end else begin
                        count_reg <= count_reg - `CNT_W'h1;
                    end
                end
                ST_CLEAR_SETTLE: begin
                    // busy at the clear: wait out the whole settle time; idle at the clear: move on once the indicator reads ready
                    if (count_reg == `CNT_W'h1 || (ready_reg && !clear_seen_busy_reg)) begin
                        state_reg <= ST_CLEAR_RELEASE;
                        count_reg <= cyc(`CLEAR_RELEASE_CYC);
                    end else if (ready_reg && count_reg > `CNT_W'h1) begin
                        count_reg <= count_reg - `CNT_W'h1;
                    end else begin
                        count_reg <= count_reg - `CNT_W'h1;
                    end
                end
                ST_CLEAR_RELEASE: begin
                    // no read before the release delay has passed
                    if (count_reg == `CNT_W'h1) begin
                        state_reg <= ST_IDLE;
                        busy_reg <= 1'h0;
                    end else begin
                        count_reg <= count_reg - `CNT_W'h1;
                    end
                end
            endcase
        end
    end

    // pin drive, all from flip-flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chip_select_n <= 1'h1;
            output_gate_n <= 1'h1;
            write_strobe_n <= 1'h1;
            hard_clear_n <= 1'h1;
            width_select_n <= 1'h1;
            accel_enable <= 1'h0;
            flash_addr <= 21'h0;
            data_out <= 16'h0;
            data_oe <= 16'h0;
        end else begin
            width_select_n <= !byte_mode_reg;
            // high voltage follows the order at once, so it stands before the first select
            if (sw_write && sw_addr == `REG_CTRL && state_reg == ST_IDLE) begin
                accel_enable <= sw_wdata[`CTRL_ACCEL];
            end
            hard_clear_n <= !(state_reg == ST_CLEAR_LOW);
            if (state_reg == ST_SETUP && !is_read_reg) begin
                flash_addr <= pin_addr(seq_word[21:0], byte_mode_reg);
                data_out <= seq_word[37:22];
                data_out[15] <= byte_mode_reg ? seq_word[0] : seq_word[37];
                data_oe <= byte_mode_reg ? 16'h80FF : 16'hFFFF;
            end else if (state_reg == ST_SETUP) begin
                flash_addr <= pin_addr(addr_reg, byte_mode_reg);
                data_out <= {addr_reg[0], 15'h0};
                data_oe <= byte_mode_reg ? 16'h8000 : 16'h0000;
            end else if (state_reg == ST_IDLE || state_reg >= ST_CLEAR_LOW) begin
                data_oe <= 16'h0;
            end
            // write: select and strobe low, gate high; read: select and gate low
            chip_select_n <= !(state_reg == ST_SETUP || state_reg == ST_STROBE
                               || state_reg == ST_READ_WAIT);
            write_strobe_n <= !(state_reg == ST_SETUP && !is_read_reg
                                || state_reg == ST_STROBE && count_reg != `CNT_W'h1);
            output_gate_n <= !(state_reg == ST_SETUP && is_read_reg
                               || state_reg == ST_READ_WAIT);
        end
    end

    // read capture at the end of the access wait
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= 16'h0;
        end else if (state_reg == ST_READ_WAIT && count_reg == `CNT_W'h1) begin
            rdata_reg <= byte_mode_reg ? {8'h0, data_in[7:0]} : data_in;
        end
    end

    // software read port, data one cycle after the strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sw_rdata <= 32'h0;
        end else if (sw_read) begin
            unique case (sw_addr)
                `REG_CTRL: sw_rdata <= {22'h0, seq_last_reg, 4'h0, accel_reg,
                                        byte_mode_reg, 2'h0};
                `REG_ADDR: sw_rdata <= {10'h0, addr_reg};
                `REG_WDATA: sw_rdata <= {16'h0, wdata_reg};
                `REG_RDATA: sw_rdata <= {16'h0, rdata_reg};
                `REG_STATUS: sw_rdata <= {29'h0, clear_seen_busy_reg, ready_reg, busy_reg};
                default: sw_rdata <= 32'h0;
            endcase
        end else begin
            sw_rdata <= 32'h0;
        end
    end
endmodule // flash_host

// [shared/flash_host_defines.svh]
// timing, field and code constants for the dual-bank flash host controller
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

// clock period in ns (25 MHz)
`define CLK_PERIOD_NS 40
// timing figures in ns, plain defaults
`define SELECT_ACCESS_NS 90
`define ADDRESS_ACCESS_NS 90
`define SLEEP_EXTRA_NS 30
`define CLEAR_PULSE_NS 500
`define CLEAR_SETTLE_NS 20000
`define CLEAR_RELEASE_NS 50
`define WRITE_PULSE_NS 35
`define RECOVER_NS 40
// cycle counts: least times round up
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELECT_ACCESS_CYC `CYC_UP(`SELECT_ACCESS_NS)
`define ADDRESS_ACCESS_CYC `CYC_UP(`ADDRESS_ACCESS_NS)
`define CLEAR_PULSE_CYC `CYC_UP(`CLEAR_PULSE_NS)
`define CLEAR_RELEASE_CYC `CYC_UP(`CLEAR_RELEASE_NS)
`define WRITE_PULSE_CYC `CYC_UP(`WRITE_PULSE_NS)
`define RECOVER_CYC `CYC_UP(`RECOVER_NS)
`define CLEAR_SETTLE_CYC `CYC_UP(`CLEAR_SETTLE_NS)

// widths
`define ADDR_W 22
`define DATA_W 16
`define CNT_W 16

// register offsets of the controller's own port
`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_WDATA 4'h2
`define REG_RDATA 4'h3
`define REG_STATUS 4'h4
`define REG_SEQ0 4'h8

// control register fields
`define CTRL_GO 0
`define CTRL_READ 1
`define CTRL_BYTE 2
`define CTRL_ACCEL 3
`define CTRL_CLEAR 4
`define CTRL_SEQ_LEN_LO 8
`define CTRL_SEQ_LEN_HI 10

// unlock sequence words (address, data) for standard program / bypass
`define UNLOCK_ADDR1 22'h000555
`define UNLOCK_ADDR2 22'h0002AA
`define UNLOCK_DATA1 16'h00AA
`define UNLOCK_DATA2 16'h0055
`define CMD_PROGRAM 16'h00A0
// sector erase command word, value arbitrary
`define CMD_SECTOR_ERASE 16'h00E5

`endif

// [shared/flash_host_pkg.sv]
// types for the dual-bank flash host controller
package flash_host_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RECOVER,
        ST_READ_WAIT,
        ST_CLEAR_LOW,
        ST_CLEAR_SETTLE,
        ST_CLEAR_RELEASE
    } host_state_t;

endpackage

// [core/seq_store.sv]
`timescale 1ns/100ps
// small memory of queued bus cycles (address and data), registered read
module seq_store
    import flash_host_pkg::*;
(
    // clock
    input wire logic clk,
    // write side
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [37:0] wr_word,
    // read side
    input wire logic [1:0] rd_idx,
    output logic [37:0] rd_word
);
    logic [37:0] mem [0:3];

    // storage, no reset needed: software fills it before use
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_word;
        end
    end

    // read data from a register
    always_ff @(posedge clk) begin
        rd_word <= mem[rd_idx];
    end
endmodule // seq_store

// [test/flash_host_sva.sv]
// pin-level assertions for the flash host controller
`timescale 1ns/100ps
`include "flash_host_defines.svh"
module flash_host_sva (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // flash pins
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic write_strobe_n,
    input wire logic hard_clear_n,
    input wire logic accel_enable,
    input wire logic [20:0] flash_addr,
    input wire logic [15:0] data_oe
);
    logic [15:0] clr_cnt_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // length of the clear pulse so far, held at the top instead of wrapping
    always_ff @(posedge clk or posedge reset) begin
        if (reset) clr_cnt_reg <= 16'h0;
        else if (hard_clear_n) clr_cnt_reg <= 16'h0;
        else if (clr_cnt_reg != 16'hFFFF) clr_cnt_reg <= clr_cnt_reg + 16'h1;
    end
    a_write_gate_high: assert property (!write_strobe_n |-> !chip_select_n && output_gate_n)
        else $error("write strobe without select or with gate low");
    a_write_addr_hold: assert property ($rose(write_strobe_n) |->
        $stable(flash_addr) && $stable(data_oe)) else $error("address moved under strobe");
    a_select_over_strobe: assert property ($rose(write_strobe_n) |-> !chip_select_n)
        else $error("select released with strobe");
    a_read_no_drive: assert property (!output_gate_n |->
        !chip_select_n && write_strobe_n && data_oe[14:0] == 15'h0) else $error("bad read cycle");
    a_accel_no_read: assert property (accel_enable |-> output_gate_n)
        else $error("read with high voltage applied");
    a_accel_when_idle: assert property ($changed(accel_enable) |-> chip_select_n)
        else $error("high voltage changed inside a cycle");
    a_clear_min_width: assert property ($rose(hard_clear_n) |->
        clr_cnt_reg >= `CLEAR_PULSE_CYC) else $error("clear pulse too short");
    a_clear_quiet: assert property (!hard_clear_n |-> write_strobe_n && output_gate_n)
        else $error("cycle issued during clear");
    a_clear_release_wait: assert property ($rose(hard_clear_n) |-> output_gate_n [*2])
        else $error("read too soon after clear");
endmodule // flash_host_sva

// [test/flash_dev_model.sv]
// behavioural dual-bank flash device seen from its pins
`timescale 1ns/100ps
`include "flash_host_defines.svh"
module flash_dev_model #(
    parameter int PROG_NS = 2000,
    parameter int SETTLE_NS = 600
)(
    // control pins
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic write_strobe_n,
    input wire logic hard_clear_n,
    input wire logic width_select_n,
    input wire logic accel_enable,
    input wire logic [20:0] flash_addr,
    // controller side of the bus, resolved bus back
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe,
    output logic [15:0] data_in,
    // ready pin and slow-read knob
    output logic completion_indicator,
    input wire logic slow
);
    logic [15:0] mem [0:255];
    logic [15:0] drv = 16'h0, drv_en = 16'h0, flt = 16'h0, wd;
    logic [20:0] wa;
    logic prog = 1'b0;
    int step = 0, tok = 0, wr_count = 0;
    time done_t = 0;
    wire rd = !chip_select_n && !output_gate_n && hard_clear_n;
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    // released lines toggle so a stale value never looks valid
    always #10 flt = ~flt;
    // ready follows the end time of the running operation
    always #10 completion_indicator = ($time >= done_t);
    // controller wins where enabled, then the device, else the pattern
    assign data_in = (data_oe & data_out) | (~data_oe & drv_en & drv)
        | (~data_oe & ~drv_en & flt);
    // reads from any bank, busy or not; data held while the address is steady
    always @(rd or flash_addr or width_select_n) begin
        drv_en = 16'h0;
        tok++;
        fork
            begin
                automatic int t = tok;
                #(slow ? 90 : 10);
                if (t == tok && rd) begin
                    drv = mem[flash_addr[7:0]];
                    // byte mode: the top line carries the low address bit
                    if (!width_select_n && data_in[15]) drv = drv >> 8;
                    drv_en = width_select_n ? 16'hFFFF : 16'h00FF;
                end
            end
        join_none
    end
    // take address and data on the strobe rise, where both are settled
    always @(posedge write_strobe_n) begin
        wa = flash_addr;
        wd = data_in;
        if (!chip_select_n && output_gate_n && hard_clear_n) begin
            wr_count++;
            if (prog) begin
                mem[wa[7:0]] = wd;
                prog = 1'b0;
                step = 0;
                done_t = $time + PROG_NS;
            end else if (wd == `CMD_PROGRAM && (accel_enable || step == 2)) prog = 1'b1;
            else if (wd == `CMD_SECTOR_ERASE && step == 2) begin
                // sectors of sixteen words, picked by the upper model address bits
                foreach (mem[j]) if (j[7:4] == wa[7:4]) mem[j] = 16'hFFFF;
                step = 0;
                done_t = $time + PROG_NS;
            end
            else if (wd == `UNLOCK_DATA1 && wa[10:0] == 11'h555) step = 1;
            else if (wd == `UNLOCK_DATA2 && wa[10:0] == 11'h2AA && step == 1) step = 2;
            else step = 0;
        end
    end
    // a clear aborts the sequence and returns to array reads
    always @(negedge hard_clear_n) begin
        prog = 1'b0;
        step = 0;
        if (!completion_indicator) done_t = $time + SETTLE_NS;
    end
endmodule // flash_dev_model

// [test/tb_top.sv]
// self-checking bench for the flash host controller
`timescale 1ns/100ps
`include "flash_host_defines.svh"
module tb_top;
    logic clk = 1'b0, reset = 1'b1, sw_write = 1'b0, sw_read = 1'b0, slow = 1'b0;
    logic [3:0] sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0, sw_rdata, rv, seed = 32'h28;
    logic chip_select_n, output_gate_n, write_strobe_n, hard_clear_n, width_select_n;
    logic accel_enable, completion_indicator;
    logic [20:0] flash_addr;
    logic [15:0] data_in, data_out, data_oe;
    logic [15:0] exp_mem [int];
    int bad_count = 0, cmp_count = 0, n_busy, n_idle, base;
    always #20 clk = ~clk;
    flash_host #(.CLEAR_SETTLE_CYCLES(20)) flash_host_i (.clk, .reset, .sw_addr, .sw_wdata,
        .sw_write, .sw_read, .sw_rdata, .chip_select_n, .output_gate_n, .write_strobe_n,
        .hard_clear_n, .width_select_n, .accel_enable, .flash_addr, .data_in, .data_out,
        .data_oe, .completion_indicator);
    flash_dev_model flash_dev_model_i (.chip_select_n, .output_gate_n, .write_strobe_n,
        .hard_clear_n, .width_select_n, .accel_enable, .flash_addr, .data_out, .data_oe,
        .data_in, .completion_indicator, .slow);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_write <= 1'b1;
        @(posedge clk);
        sw_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_read <= 1'b1;
        @(posedge clk);
        sw_read <= 1'b0;
        #1 d = sw_rdata;
    endtask
    // poll busy under a bound; the poll count measures the operation
    task automatic idle(output int n);
        rv = 32'h1;
        for (n = 0; n < 300 && rv[0] !== 1'b0; n++) rd(`REG_STATUS, rv);
        chk("busy flag", 32'h0, {31'h0, rv[0]});
    endtask
    // queue the words and start; bypass needs two, the plain sequence four
    task automatic prog(input logic [7:0] a, input logic [15:0] d, input bit byp);
        int n;
        if (byp) wr(`REG_SEQ0, {`CMD_PROGRAM, 16'h0555});
        else begin
            wr(`REG_SEQ0, {`UNLOCK_DATA1, 16'h0555});
            wr(`REG_SEQ0 + 4'h1, {`UNLOCK_DATA2, 16'h02AA});
            wr(`REG_SEQ0 + 4'h2, {`CMD_PROGRAM, 16'h0555});
        end
        wr(byp ? `REG_SEQ0 + 4'h1 : `REG_SEQ0 + 4'h3, {d, 8'h0, a});
        base = flash_dev_model_i.wr_count;
        wr(`REG_CTRL, byp ? 32'h109 : 32'h301);
        idle(n);
        chk("write cycles", byp ? 2 : 4, flash_dev_model_i.wr_count - base);
        exp_mem[a] = d;
        wr(`REG_CTRL, 32'h0);
    endtask
    task automatic fread(input logic [7:0] a);
        int n;
        wr(`REG_ADDR, {24'h0, a});
        wr(`REG_CTRL, 32'h3);
        idle(n);
        rd(`REG_RDATA, rv);
        chk("read data", exp_mem.exists(a) ? {16'h0, exp_mem[a]} : 32'hFFFF, rv & 32'hFFFF);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        logic [31:0] r;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1 chk("pins at reset", 32'hF, {accel_enable, chip_select_n, output_gate_n,
            write_strobe_n, hard_clear_n});
        chk("bus at reset", 32'h0, data_oe);
        rd(`REG_STATUS, rv);
        chk("status at reset", 32'h0, rv & 32'h5);
        rd(4'h6, rv);
        chk("unmapped", 32'h0, rv);
        $display("test reset done");
        // plain and bypass programs, each read back while the device is busy
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            prog(r[7:0], r[31:16], i[0]);
            #1 chk("accel off", 32'h0, accel_enable);
            slow <= i[1];
            fread(r[7:0]);
        end
        // byte read of the odd byte of the last programmed word
        wr(`REG_ADDR, {23'h0, r[7:0], 1'b1});
        wr(`REG_CTRL, 32'h7);
        idle(n_idle);
        chk("width select", 32'h0, width_select_n);
        rd(`REG_RDATA, rv);
        chk("byte read", {24'h0, exp_mem[r[7:0]][15:8]}, rv);
        $display("test program done");
        // clear mid-program with a refused start, then a clear while idle
        prog(8'h3C, 16'h1234, 1'b0);
        wr(`REG_CTRL, 32'h10);
        base = flash_dev_model_i.wr_count;
        wr(`REG_CTRL, 32'h301);
        idle(n_busy);
        chk("refused go", base, flash_dev_model_i.wr_count);
        rd(`REG_STATUS, rv);
        chk("busy clear flags", 32'h6, rv & 32'h7);
        wr(`REG_CTRL, 32'h10);
        idle(n_idle);
        rd(`REG_STATUS, rv);
        chk("idle clear flags", 32'h2, rv & 32'h7);
        chk("idle clear shorter", 32'h1, {31'h0, n_idle < n_busy});
        prog(8'h3C, 16'h1234, 1'b0);
        fread(8'h3C);
        // sector erase through a three-word queue, then word 3C of the sector reads blank
        wr(`REG_SEQ0, {`UNLOCK_DATA1, 16'h0555});
        wr(`REG_SEQ0 + 4'h1, {`UNLOCK_DATA2, 16'h02AA});
        wr(`REG_SEQ0 + 4'h2, {`CMD_SECTOR_ERASE, 16'h0030});
        base = flash_dev_model_i.wr_count;
        wr(`REG_CTRL, 32'h201);
        idle(n_idle);
        chk("erase cycles", 3, flash_dev_model_i.wr_count - base);
        for (int k = 8'h30; k < 8'h40; k++) exp_mem[k] = 16'hFFFF;
        fread(8'h3C);
        #1 chk("standby pins", 32'h7, {chip_select_n, output_gate_n, write_strobe_n});
        $display("test clear done");
        summarize();
    end
    // cut a hang short, far beyond the expected run
    initial begin
        #(40 * 20000);
        bad_count++;
        summarize();
    end
endmodule // tb_top
bind flash_host flash_host_sva flash_host_sva_i (.clk, .reset, .chip_select_n, .output_gate_n,
    .write_strobe_n, .hard_clear_n, .accel_enable, .flash_addr, .data_oe);
